// ---- rtl/rspi_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// R1: Writing 1 to indicator reset clears indicators and releases latched relay.
// R2: Writing 1 to full reset also erases all recorded value registers.
// R3: Bank select reads and writes; 0 main settings, 1 second settings.
// R4: Four event masks, ranges 0-4096, 0-4096, 0-255 and 0-1023.
// R5: Writing the right password, 1 to 999, opens remote setting.
// R6: Password change or close, 0 to 999, accepted only while open.
// R7: Writing 1 to supervision activation lights the internal fault lamp.
// R8: Writing 2 to memory format while open formats memory; key fault is 56.
// R9: Station address reads and writes, accepting 1 to 254.
// R10: Baud rate reads 4800 or 9600, writes 4.8 or 9.6 kilobaud.
// R11: Event register holds 65 events with time, channel and code.
// R12: Each fetch returns the next five events, each only once.
// R13: Refetch returns the last fetched events again, repeatably.
// R14: Module state reads 0 normal, 1 auto reset, 2 overflow, 3 both.
// R15: Writing 0 to module state clears it.
// R16: Time reads and sets, 0 to 59.999 s in milliseconds.
// R17: Internal fault lights lamp and drops the supervision alarm relay.
// R18: Fault shows red 1 plus green code, also readable 0 to 255.
// R19: Memory fault codes 30, 50, 51-53 and 54.
// R20: Reference channel codes 195, 131, 67 low; 203, 139, 75 high.
// R21: Codes 4 relay circuit, 252 neutral filter, 253 converter stalled.
// R22: Writes to read-only parameters or out-of-range values are ignored.
module rspi_top
	import rspi_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF,
	parameter int DEPTH     = EVT_DEPTH,
	parameter int BATCH     = FETCH_BATCH
)(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        req_valid,
	input  wire rspi_req_t   req,
	output logic             req_ready,
	output logic             rsp_valid,
	output rspi_rsp_t        rsp,
	input  wire logic        event_valid,
	input  wire logic [3:0]  event_channel,
	input  wire logic [7:0]  event_code,
	input  wire logic        auto_reset_seen,
	input  wire rspi_fault_t faults,
	output logic             indicator_clear,
	output logic             latch_release,
	output logic             records_clear,
	output logic             memory_format_start,
	output logic             setting_bank_select,
	output logic [12:0]      overcurrent_event_mask,
	output logic [12:0]      residual_event_mask,
	output logic [7:0]       output_event_mask_a,
	output logic [9:0]       output_event_mask_b,
	output logic [7:0]       bus_station_address,
	output logic             baud_rate_select,
	output logic             remote_setting_open,
	output logic             internal_fault_lamp,
	output logic             alarm_relay_energized,
	output logic             display_red_one,
	output logic [7:0]       display_code,
	output logic [15:0]      time_ms
);

	localparam int DW = $clog2(MS_CYCLES + 1);

	typedef enum logic {
		ST_IDLE,
		ST_STREAM
	} rspi_phase_t;

	typedef struct packed {
		rspi_phase_t   phase;
		logic          bank_second;
		logic [12:0]   mask_oc;
		logic [12:0]   mask_res;
		logic [7:0]    mask_a;
		logic [9:0]    mask_b;
		logic [9:0]    password;
		logic          pw_open;
		logic          sv_test;
		logic [7:0]    address;
		logic          baud_hi;
		logic          auto_flag;
		logic          ovf_flag;
		logic [15:0]   time_ms;
		logic [DW-1:0] div;
		logic          ind_clr;
		logic          latch_rel;
		logic          rec_clr;
		logic          fmt_go;
		logic          fault_on;
		logic [7:0]    fault_code;
		logic          rsp_valid;
		rspi_rsp_t     rsp;
	} rspi_state_t;

	logic [1:0]  rst_sync;
	logic        rst_n;
	rspi_state_t s;
	rspi_state_t next_s;
	logic        buf_fetch;
	logic        buf_refetch;
	logic        buf_step;
	rspi_event_t buf_head;
	logic [3:0]  buf_remaining;
	logic        buf_overflow;
	logic        enc_present;
	logic [7:0]  enc_code;
	rspi_event_t stamped;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign rst_n = rst_sync[1];

	assign stamped = '{time_ms: s.time_ms, channel: event_channel, code: event_code};

	rspi_event_buffer #(
		.DEPTH (DEPTH),
		.BATCH (BATCH)
	) u_events (
		.clk       (clk),
		.rst_n     (rst_n),
		.push      (event_valid),
		.push_data (stamped),
		.fetch     (buf_fetch),
		.refetch   (buf_refetch),
		.step      (buf_step),
		.head      (buf_head),
		.remaining (buf_remaining),
		.overflow  (buf_overflow)
	);

	rspi_fault_encoder u_faults (
		.faults  (faults),
		.present (enc_present),
		.code    (enc_code)
	);

	always_comb begin
		logic [31:0] v;
		logic        wr;
		v           = req.value;
		wr          = req.write;
		next_s      = s;
		buf_fetch   = 1'b0;
		buf_refetch = 1'b0;
		buf_step    = 1'b0;
		next_s.rsp_valid = 1'b0;
		next_s.ind_clr   = 1'b0;
		next_s.latch_rel = 1'b0;
		next_s.rec_clr   = 1'b0;
		next_s.fmt_go    = 1'b0;

		// Millisecond clock; a time write later in this process overrides the tick.
		if (s.div == DW'(MS_CYCLES - 1)) begin
			next_s.div = '0;
			if ({16'h0000, s.time_ms} == TIME_MAX_MS) begin
				next_s.time_ms = 16'h0000;                            // [R16]
			end else begin
				next_s.time_ms = s.time_ms + 16'h0001;                // [R16]
			end
		end else begin
			next_s.div = s.div + DW'(1);
		end

		case (s.phase)
			ST_IDLE: begin
				if (req_valid) begin
					next_s.rsp_valid = 1'b1;
					next_s.rsp       = '0;
					next_s.rsp.last  = 1'b1;
					case (req.param)
						PID_INDICATOR_RESET: begin
							if (wr && v == VAL_ONE) begin
								next_s.ind_clr   = 1'b1;              // [R1]
								next_s.latch_rel = 1'b1;              // [R1]
								next_s.sv_test   = 1'b0;
								next_s.rsp.ok    = 1'b1;
							end
						end
						PID_FULL_RESET: begin
							if (wr && v == VAL_ONE) begin
								next_s.ind_clr   = 1'b1;              // [R2]
								next_s.latch_rel = 1'b1;              // [R2]
								next_s.rec_clr   = 1'b1;              // [R2]
								next_s.sv_test   = 1'b0;
								next_s.rsp.ok    = 1'b1;
							end
						end
						PID_SETTING_BANK: begin
							if (!wr) begin
								next_s.rsp.ok   = 1'b1;
								next_s.rsp.data = {31'h0, s.bank_second};   // [R3]
							end else if (v <= VAL_ONE) begin
								next_s.bank_second = v[0];                  // [R3]
								next_s.rsp.ok      = 1'b1;
							end
						end
						PID_MASK_OC: begin
							if (!wr) begin
								next_s.rsp.ok   = 1'b1;
								next_s.rsp.data = {19'h0, s.mask_oc};       // [R4]
							end else if (v <= MASK_OC_MAX) begin
								next_s.mask_oc = v[12:0];                   // [R4]
								next_s.rsp.ok  = 1'b1;
							end
						end
						PID_MASK_RES: begin
							if (!wr) begin
								next_s.rsp.ok   = 1'b1;
								next_s.rsp.data = {19'h0, s.mask_res};      // [R4]
							end else if (v <= MASK_OC_MAX) begin
								next_s.mask_res = v[12:0];                  // [R4]
								next_s.rsp.ok   = 1'b1;
							end
						end
						PID_MASK_A: begin
							if (!wr) begin
								next_s.rsp.ok   = 1'b1;
								next_s.rsp.data = {24'h0, s.mask_a};        // [R4]
							end else if (v <= MASK_A_MAX) begin
								next_s.mask_a = v[7:0];                     // [R4]
								next_s.rsp.ok = 1'b1;
							end
						end
						PID_MASK_B: begin
							if (!wr) begin
								next_s.rsp.ok   = 1'b1;
								next_s.rsp.data = {22'h0, s.mask_b};        // [R4]
							end else if (v <= MASK_B_MAX) begin
								next_s.mask_b = v[9:0];                     // [R4]
								next_s.rsp.ok = 1'b1;
							end
						end
						PID_PASSWORD_OPEN: begin
							// A wrong guess leaves the lock as it was.
							if (wr && v >= VAL_ONE && v <= PASSWORD_MAX
									&& v[9:0] == s.password) begin
								next_s.pw_open = 1'b1;                      // [R5]
								next_s.rsp.ok  = 1'b1;
							end
						end
						PID_PASSWORD_CHANGE: begin
							if (wr && s.pw_open && v <= PASSWORD_MAX) begin
								next_s.password = v[9:0];                   // [R6]
								next_s.pw_open  = 1'b0;                     // [R6]
								next_s.rsp.ok   = 1'b1;
							end
						end
						PID_SUPERVISION: begin
							if (wr && v == VAL_ONE) begin
								next_s.sv_test = 1'b1;                      // [R7]
								next_s.rsp.ok  = 1'b1;
							end
						end
						PID_MEMORY_FORMAT: begin
							if (wr && s.pw_open && v == VAL_FORMAT) begin
								next_s.fmt_go = 1'b1;                       // [R8]
								next_s.rsp.ok = 1'b1;
							end
						end
						PID_FAULT_CODE: begin
							if (!wr) begin
								next_s.rsp.ok   = 1'b1;
								next_s.rsp.data = {24'h0, s.fault_code};    // [R18]
							end
						end
						PID_ADDRESS: begin
							if (!wr) begin
								next_s.rsp.ok   = 1'b1;
								next_s.rsp.data = {24'h0, s.address};       // [R9]
							end else if (v >= ADDR_MIN && v <= ADDR_MAX) begin
								next_s.address = v[7:0];                    // [R9]
								next_s.rsp.ok  = 1'b1;
							end
						end
						PID_BAUD: begin
							if (!wr) begin
								next_s.rsp.ok   = 1'b1;
								next_s.rsp.data = s.baud_hi ? BAUD_RD_HI : BAUD_RD_LO;  // [R10]
							end else if (v == BAUD_WR_HI || v == BAUD_WR_LO) begin
								next_s.baud_hi = (v == BAUD_WR_HI);                     // [R10]
								next_s.rsp.ok  = 1'b1;
							end
						end
						CMD_EVENT_FETCH: begin
							if (!wr) begin
								buf_fetch        = 1'b1;                    // [R12]
								next_s.phase     = ST_STREAM;
								next_s.rsp_valid = 1'b0;
							end
						end
						CMD_EVENT_REFETCH: begin
							if (!wr) begin
								buf_refetch      = 1'b1;                    // [R13]
								next_s.phase     = ST_STREAM;
								next_s.rsp_valid = 1'b0;
							end
						end
						CMD_MODULE_STATE: begin
							if (!wr) begin
								next_s.rsp.ok   = 1'b1;
								next_s.rsp.data = {30'h0, s.ovf_flag, s.auto_flag};  // [R14]
							end else if (v == 32'h0000_0000) begin
								next_s.auto_flag = 1'b0;                    // [R15]
								next_s.ovf_flag  = 1'b0;                    // [R15]
								next_s.rsp.ok    = 1'b1;
							end
						end
						CMD_TIME: begin
							if (!wr) begin
								next_s.rsp.ok   = 1'b1;
								next_s.rsp.data = {16'h0000, s.time_ms};    // [R16]
							end else if (v <= TIME_MAX_MS) begin
								next_s.time_ms = v[15:0];                   // [R16]
								next_s.div     = '0;
								next_s.rsp.ok  = 1'b1;
							end
						end
						default: begin
							next_s.rsp.ok = 1'b0;                           // [R22]
						end
					endcase
				end
			end
			ST_STREAM: begin
				next_s.rsp_valid = 1'b1;
				next_s.rsp.ok    = 1'b1;
				if (buf_remaining == 4'h0) begin
					// An empty register still answers once, with no event in it.
					next_s.rsp.evt  = 1'b0;
					next_s.rsp.last = 1'b1;
					next_s.rsp.data = 32'h0000_0000;
					next_s.phase    = ST_IDLE;
				end else begin
					buf_step        = 1'b1;
					next_s.rsp.evt  = 1'b1;
					next_s.rsp.last = (buf_remaining == 4'h1);
					next_s.rsp.data = {4'h0, buf_head};                     // [R11]
					if (buf_remaining == 4'h1) begin
						next_s.phase = ST_IDLE;
					end
				end
			end
			default: begin
				next_s.phase = ST_IDLE;
			end
		endcase

		// Hardware sets come last so they win over a clear in the same cycle.
		if (auto_reset_seen) begin
			next_s.auto_flag = 1'b1; // [R14]
		end
		if (buf_overflow) begin
			next_s.ovf_flag = 1'b1; // [R14]
		end

		next_s.fault_on   = enc_present | next_s.sv_test; // [R17]
		next_s.fault_code = enc_code; // [R18]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s             <= '0;
			s.phase       <= ST_IDLE;
			s.bank_second <= BANK_RESET;
			s.password    <= PASSWORD_RESET;
			s.address     <= ADDR_RESET;
			s.baud_hi     <= BAUD_HI_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign req_ready              = (s.phase == ST_IDLE);
	assign rsp_valid              = s.rsp_valid;
	assign rsp                    = s.rsp;
	assign indicator_clear        = s.ind_clr;
	assign latch_release          = s.latch_rel;
	assign records_clear          = s.rec_clr;
	assign memory_format_start    = s.fmt_go;
	assign setting_bank_select    = s.bank_second;
	assign overcurrent_event_mask = s.mask_oc;
	assign residual_event_mask    = s.mask_res;
	assign output_event_mask_a    = s.mask_a;
	assign output_event_mask_b    = s.mask_b;
	assign bus_station_address    = s.address;
	assign baud_rate_select       = s.baud_hi;
	assign remote_setting_open    = s.pw_open;
	assign internal_fault_lamp    = s.fault_on; // [R17]
	assign alarm_relay_energized  = ~s.fault_on; // [R17]
	assign display_red_one        = s.fault_on; // [R18]
	assign display_code           = s.fault_code;
	assign time_ms                = s.time_ms;

endmodule : rspi_top

// ---- rtl/rspi_pkg.sv ----
package rspi_pkg;

	// Parameter numbers as the communicator addresses them.
	localparam logic [7:0] PID_INDICATOR_RESET = 8'h65;
	localparam logic [7:0] PID_FULL_RESET      = 8'h66;
	localparam logic [7:0] PID_SETTING_BANK    = 8'h96;
	localparam logic [7:0] PID_MASK_OC         = 8'h9B;
	localparam logic [7:0] PID_MASK_RES        = 8'h9C;
	localparam logic [7:0] PID_MASK_A          = 8'h9D;
	localparam logic [7:0] PID_MASK_B          = 8'h9E;
	localparam logic [7:0] PID_PASSWORD_OPEN   = 8'hA0;
	localparam logic [7:0] PID_PASSWORD_CHANGE = 8'hA1;
	localparam logic [7:0] PID_SUPERVISION     = 8'hA5;
	localparam logic [7:0] PID_MEMORY_FORMAT   = 8'hA7;
	localparam logic [7:0] PID_FAULT_CODE      = 8'hA9;
	localparam logic [7:0] PID_ADDRESS         = 8'hC8;
	localparam logic [7:0] PID_BAUD            = 8'hC9;
	// Letter commands, coded above the numbered parameters.
	localparam logic [7:0] CMD_EVENT_FETCH     = 8'hF0;
	localparam logic [7:0] CMD_EVENT_REFETCH   = 8'hF1;
	localparam logic [7:0] CMD_MODULE_STATE    = 8'hF2;
	localparam logic [7:0] CMD_TIME            = 8'hF3;

	localparam logic [31:0] VAL_ONE        = 32'h0000_0001;
	localparam logic [31:0] VAL_FORMAT     = 32'h0000_0002;
	localparam logic [31:0] MASK_OC_MAX    = 32'h0000_1000;
	localparam logic [31:0] MASK_A_MAX     = 32'h0000_00FF;
	localparam logic [31:0] MASK_B_MAX     = 32'h0000_03FF;
	localparam logic [31:0] PASSWORD_MAX   = 32'h0000_03E7;
	localparam logic [31:0] ADDR_MIN       = 32'h0000_0001;
	localparam logic [31:0] ADDR_MAX       = 32'h0000_00FE;
	localparam logic [31:0] BAUD_RD_LO     = 32'h0000_12C0;
	localparam logic [31:0] BAUD_RD_HI     = 32'h0000_2580;
	localparam logic [31:0] BAUD_WR_LO     = 32'h0000_0030;
	localparam logic [31:0] BAUD_WR_HI     = 32'h0000_0060;
	localparam logic [31:0] TIME_MAX_MS    = 32'h0000_EA5F;

	localparam logic [9:0]  PASSWORD_RESET = 10'h001;
	localparam logic [7:0]  ADDR_RESET     = 8'h01;
	localparam logic        BAUD_HI_RESET  = 1'b1;
	localparam logic        BANK_RESET     = 1'b0;

	localparam int EVT_DEPTH     = 65;
	localparam int FETCH_BATCH   = 5;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_PERIOD_NS  = 1000000;
	localparam int MS_CYCLES_DEF = MS_PERIOD_NS / CLK_PERIOD_NS;

	localparam logic [7:0] FC_RELAY_CTRL = 8'h04;
	localparam logic [7:0] FC_ROM        = 8'h1E;
	localparam logic [7:0] FC_RAM        = 8'h32;
	localparam logic [7:0] FC_PM_BLK1    = 8'h33;
	localparam logic [7:0] FC_PM_BLK2    = 8'h34;
	localparam logic [7:0] FC_PM_BOTH    = 8'h35;
	localparam logic [7:0] FC_PM_CKSUM   = 8'h36;
	localparam logic [7:0] FC_PM_KEY     = 8'h38;
	localparam logic [7:0] FC_REF_LO_1   = 8'hC3;
	localparam logic [7:0] FC_REF_LO_5   = 8'h83;
	localparam logic [7:0] FC_REF_LO_25  = 8'h43;
	localparam logic [7:0] FC_REF_HI_1   = 8'hCB;
	localparam logic [7:0] FC_REF_HI_5   = 8'h8B;
	localparam logic [7:0] FC_REF_HI_25  = 8'h4B;
	localparam logic [7:0] FC_FILTER_I0  = 8'hFC;
	localparam logic [7:0] FC_ADC_STALL  = 8'hFD;

	typedef struct packed {
		logic        write;
		logic [7:0]  param;
		logic [31:0] value;
	} rspi_req_t;

	typedef struct packed {
		logic        ok;
		logic        evt;
		logic        last;
		logic [31:0] data;
	} rspi_rsp_t;

	typedef struct packed {
		logic [15:0] time_ms;
		logic [3:0]  channel;
		logic [7:0]  code;
	} rspi_event_t;

	typedef struct packed {
		logic       relay_ctrl;
		logic       rom;
		logic       ram;
		logic       pm_blk1;
		logic       pm_blk2;
		logic       pm_cksum;
		logic       pm_key;
		logic [2:0] ref_low;
		logic [2:0] ref_high;
		logic       filter_i0;
		logic       adc_stall;
	} rspi_fault_t;

endpackage : rspi_pkg

// ---- rtl/rspi_fault_encoder.sv ----
`timescale 1ns/1ps
module rspi_fault_encoder
	import rspi_pkg::*;
(
	input  wire rspi_fault_t faults,
	output logic             present,
	output logic [7:0]       code
);

	// Memory faults win because a broken store makes every later code suspect.
	always_comb begin
		present = 1'b1;
		if (faults.rom) code = FC_ROM; // [R19]
		else if (faults.ram) code = FC_RAM; // [R19]
		else if (faults.pm_blk1 && faults.pm_blk2) code = FC_PM_BOTH; // [R19]
		else if (faults.pm_blk1) code = FC_PM_BLK1; // [R19]
		else if (faults.pm_blk2) code = FC_PM_BLK2; // [R19]
		else if (faults.pm_cksum) code = FC_PM_CKSUM; // [R19]
		else if (faults.pm_key) code = FC_PM_KEY; // [R8]
		else if (faults.ref_low[0]) code = FC_REF_LO_1; // [R20]
		else if (faults.ref_low[1]) code = FC_REF_LO_5; // [R20]
		else if (faults.ref_low[2]) code = FC_REF_LO_25; // [R20]
		else if (faults.ref_high[0]) code = FC_REF_HI_1; // [R20]
		else if (faults.ref_high[1]) code = FC_REF_HI_5; // [R20]
		else if (faults.ref_high[2]) code = FC_REF_HI_25; // [R20]
		else if (faults.relay_ctrl) code = FC_RELAY_CTRL; // [R21]
		else if (faults.filter_i0) code = FC_FILTER_I0; // [R21]
		else if (faults.adc_stall) code = FC_ADC_STALL; // [R21]
		else begin
			present = 1'b0;
			code    = 8'h00;
		end
	end

endmodule : rspi_fault_encoder

// ---- rtl/rspi_event_buffer.sv ----
`timescale 1ns/1ps
module rspi_event_buffer
	import rspi_pkg::*;
#(
	parameter int DEPTH = EVT_DEPTH,
	parameter int BATCH = FETCH_BATCH
)(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        push,
	input  wire rspi_event_t push_data,
	input  wire logic        fetch,
	input  wire logic        refetch,
	input  wire logic        step,
	output rspi_event_t      head,
	output logic [3:0]       remaining,
	output logic             overflow
);

	localparam int PW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [PW-1:0] fill;
		logic [PW-1:0] bstart;
		logic [3:0]    bcount;
		logic [PW-1:0] sptr;
		logic [3:0]    srem;
		logic          ovf;
	} rspi_buf_t;

	rspi_buf_t   s;
	rspi_buf_t   next_s;
	rspi_event_t mem [DEPTH];

	function automatic logic [PW-1:0] wrap_add(input logic [PW-1:0] a, input logic [PW-1:0] b);
		logic [PW:0] sum;
		sum = {1'b0, a} + {1'b0, b};
		if (sum >= (PW + 1)'(DEPTH)) sum = sum - (PW + 1)'(DEPTH);
		return sum[PW-1:0];
	endfunction : wrap_add

	always_comb begin
		logic [PW-1:0] take;
		take   = '0;
		next_s = s;
		next_s.ovf = 1'b0;
		if (fetch) begin
			take = (s.fill < PW'(BATCH)) ? s.fill : PW'(BATCH); // [R12]
			next_s.bstart = s.rd;
			next_s.bcount = take[3:0];
			next_s.sptr   = s.rd;
			next_s.srem   = take[3:0];
			next_s.rd     = wrap_add(s.rd, take); // [R12]
		end else if (refetch) begin
			next_s.sptr = s.bstart; // [R13]
			next_s.srem = s.bcount; // [R13]
		end else if (step && s.srem != 4'h0) begin
			next_s.sptr = wrap_add(s.sptr, PW'(1));
			next_s.srem = s.srem - 4'h1;
		end
		next_s.fill = s.fill - take;
		if (push) begin
			if (s.fill == PW'(DEPTH)) begin
				next_s.ovf = 1'b1; // [R11]
			end else begin
				next_s.wr   = wrap_add(s.wr, PW'(1));
				next_s.fill = next_s.fill + PW'(1); // [R11]
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// The array holds no reset so it can map onto plain memory.
	always_ff @(posedge clk) begin
		if (push && s.fill != PW'(DEPTH)) begin
			mem[s.wr] <= push_data; // [R11]
		end
	end

	assign head      = mem[s.sptr];
	assign remaining = s.srem;
	assign overflow  = s.ovf;

endmodule : rspi_event_buffer

// ---- tb/rspi_top_asserts.sv ----
`timescale 1ns/1ps
module rspi_top_asserts
	import rspi_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        req_valid,
	input wire rspi_req_t   req,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	input wire rspi_rsp_t   rsp,
	input wire rspi_fault_t faults,
	input wire logic        latch_release,
	input wire logic        setting_bank_select,
	input wire logic        alarm_relay_energized,
	input wire logic        internal_fault_lamp,
	input wire logic [7:0]  display_code,
	input wire logic [15:0] time_ms
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire tk = req_valid && req_ready;
	wire wr1 = tk && req.write && req.value == VAL_ONE;
	property p_bank; wr1 && req.param == PID_SETTING_BANK |=> setting_bank_select; endproperty
	a_bank: assert property (p_bank) else $error("bank not taken");
	property p_ind; wr1 && req.param == PID_INDICATOR_RESET |=> latch_release && rsp.ok; endproperty
	a_ind: assert property (p_ind) else $error("no latch release");
	property p_ro; tk && req.write && req.param == PID_FAULT_CODE |=> rsp_valid && !rsp.ok; endproperty
	a_ro: assert property (p_ro) else $error("read-only write accepted");
	property p_alarm; alarm_relay_energized != internal_fault_lamp; endproperty
	a_alarm: assert property (p_alarm) else $error("alarm not inverse of lamp");
	property p_rom; faults.rom |=> display_code == FC_ROM; endproperty
	a_rom: assert property (p_rom) else $error("rom code wrong");
	property p_adc; faults.adc_stall && $countones(faults) == 1 |=> display_code == 8'hFD; endproperty
	a_adc: assert property (p_adc) else $error("converter code wrong");
	property p_time; {16'h0000, time_ms} <= TIME_MAX_MS; endproperty
	a_time: assert property (p_time) else $error("time out of range");
	property p_fetch; tk && !req.write && req.param == CMD_EVENT_FETCH |=> !rsp_valid ##1 rsp_valid; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch answer late");
	c_fetch: cover property (tk && req.param == CMD_EVENT_FETCH);
	c_last: cover property (rsp_valid && rsp.evt && rsp.last);
	c_lamp: cover property ($rose(internal_fault_lamp));
endmodule : rspi_top_asserts
bind rspi_top rspi_top_asserts chk_u (.clk, .reset_n, .req_valid, .req, .req_ready, .rsp_valid,
	.rsp, .faults, .latch_release, .setting_bank_select, .alarm_relay_energized,
	.internal_fault_lamp, .display_code, .time_ms);

// ---- tb/rspi_comm_model.sv ----
`timescale 1ns/1ps
module rspi_comm_model
	import rspi_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      req_ready,
	input  wire logic      rsp_valid,
	input  wire rspi_rsp_t rsp,
	output logic           req_valid,
	output rspi_req_t      req
);
	rspi_rsp_t q[$];
	initial begin
		req_valid = 1'b0;
		req = '0;
	end
	// Released lines show their inverse so stale samples stand out.
	task automatic xfer(input logic w, input logic [7:0] p, input logic [31:0] v);
		int n;
		q.delete();
		req_valid <= 1'b1;
		req <= '{write: w, param: p, value: v};
		do @(negedge clk); while (req_ready !== 1'b1);
		@(posedge clk);
		req_valid <= 1'b0;
		req <= rspi_req_t'(~req);
		n = 0;
		while (n < 12 && (q.size() == 0 || rsp_valid === 1'b1)) begin
			@(posedge clk);
			if (rsp_valid === 1'b1) q.push_back(rsp);
			n++;
		end
	endtask : xfer
endmodule : rspi_comm_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench
	import rspi_pkg::*;
;
	localparam int MS = 1000;
	logic        clk = 0;
	logic        reset_n = 0;
	logic        event_valid = 0;
	logic        auto_reset_seen = 0;
	logic [3:0]  event_channel = '0;
	logic [7:0]  event_code = '0;
	rspi_fault_t faults = '0;
	logic        req_valid, req_ready, rsp_valid, remote_setting_open;
	logic        internal_fault_lamp, alarm_relay_energized, display_red_one;
	rspi_req_t   req;
	rspi_rsp_t   rsp;
	logic [7:0]  display_code;
	logic [15:0] time_ms;
	logic [31:0] lfsr = 32'h2616;
	int          err_count = 0, compares = 0, cyc = 0;
	rspi_top #(.MS_CYCLES(MS)) dut_u (.clk, .reset_n, .req_valid, .req, .req_ready, .rsp_valid,
		.rsp, .event_valid, .event_channel, .event_code, .auto_reset_seen, .faults,
		.indicator_clear(), .latch_release(), .records_clear(), .memory_format_start(),
		.setting_bank_select(), .overcurrent_event_mask(), .residual_event_mask(),
		.output_event_mask_a(), .output_event_mask_b(), .bus_station_address(),
		.baud_rate_select(), .remote_setting_open, .internal_fault_lamp, .alarm_relay_energized,
		.display_red_one, .display_code, .time_ms);
	rspi_comm_model comm_u (.clk, .req_ready, .rsp_valid, .rsp, .req_valid, .req);
	initial forever #5 clk = ~clk;
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		$display("mismatches %0d, compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		int mx[6] = '{1, 4096, 4096, 255, 1023, 254};
		logic [7:0] pid[6] = '{PID_SETTING_BANK, PID_MASK_OC, PID_MASK_RES, PID_MASK_A,
			PID_MASK_B, PID_ADDRESS};
		int val[6] = '{0, 0, 0, 0, 0, 1};
		int fc[15] = '{253, 252, 203, 139, 75, 195, 131, 67, 56, 54, 52, 51, 50, 30, 4};
		int evq[$];
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			comm_u.xfer(0, pid[i], 0);
			check(comm_u.q[0].data, val[i]);
			val[i] = mx[i] - (rnd() % mx[i]);
			comm_u.xfer(1, pid[i], val[i]);
			comm_u.xfer(1, pid[i], mx[i] + 1);
			check(comm_u.q[0].ok, 0);
			comm_u.xfer(0, pid[i], 0);
			check(comm_u.q[0].data, val[i]);
		end
		comm_u.xfer(0, PID_BAUD, 0);
		check(comm_u.q[0].data, 9600);
		comm_u.xfer(1, PID_BAUD, 48);
		comm_u.xfer(0, PID_BAUD, 0);
		check(comm_u.q[0].data, 4800);
		comm_u.xfer(1, PID_FAULT_CODE, 5);
		comm_u.xfer(1, PID_PASSWORD_CHANGE, 7);
		check(comm_u.q[0].ok, 0);
		comm_u.xfer(1, PID_PASSWORD_OPEN, 2);
		check(remote_setting_open, 0);
		comm_u.xfer(1, PID_PASSWORD_OPEN, 1);
		check(remote_setting_open, 1);
		comm_u.xfer(1, PID_MEMORY_FORMAT, 2);
		check(comm_u.q[0].ok, 1);
		comm_u.xfer(1, PID_PASSWORD_CHANGE, 7);
		comm_u.xfer(1, PID_PASSWORD_OPEN, 7);
		check(remote_setting_open, 1);
		comm_u.xfer(1, PID_SUPERVISION, 1);
		check(internal_fault_lamp, 1);
		comm_u.xfer(1, PID_INDICATOR_RESET, 1);
		check(internal_fault_lamp, 0);
		comm_u.xfer(1, PID_FULL_RESET, 1);
		check(comm_u.q[0].ok, 1);
		for (int i = 0; i < 16; i++) begin
			faults <= (i < 15) ? rspi_fault_t'(15'h0001 << i) : rspi_fault_t'(15'h0C00);
			repeat (2) @(posedge clk);
			check(display_code, (i < 15) ? fc[i] : 53);
			check(alarm_relay_energized, 0);
			check(display_red_one, 1);
		end
		comm_u.xfer(0, PID_FAULT_CODE, 0);
		check(comm_u.q[0].data, 53);
		faults <= '0;
		comm_u.xfer(1, CMD_TIME, 59999);
		comm_u.xfer(0, CMD_TIME, 0);
		check(comm_u.q[0].data, 59999);
		comm_u.xfer(0, CMD_EVENT_FETCH, 0);
		check(comm_u.q[0].evt, 0);
		comm_u.xfer(1, CMD_TIME, 1234);
		for (int i = 0; i < 66; i++) begin
			event_valid <= 1'b1;
			event_code <= 8'(rnd());
			event_channel <= 4'(i);
			@(posedge clk);
			if (i < 65) evq.push_back({4'h0, 16'd1234, event_channel, event_code});
		end
		event_valid <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			comm_u.xfer(0, (k % 2) ? CMD_EVENT_REFETCH : CMD_EVENT_FETCH, 0);
			check(comm_u.q.size(), 5);
			for (int j = 0; j < 5; j++) check(comm_u.q[j].data, evq[j]);
			if (k % 2) repeat (5) void'(evq.pop_front());
		end
		comm_u.xfer(0, CMD_MODULE_STATE, 0);
		check(comm_u.q[0].data, 2);
		auto_reset_seen <= 1'b1;
		@(posedge clk);
		auto_reset_seen <= 1'b0;
		comm_u.xfer(0, CMD_MODULE_STATE, 0);
		check(comm_u.q[0].data, 3);
		comm_u.xfer(1, CMD_MODULE_STATE, 0);
		comm_u.xfer(0, CMD_MODULE_STATE, 0);
		check(comm_u.q[0].data, 0);
		comm_u.xfer(1, CMD_TIME, 59999);
		repeat (MS + MS / 2) @(posedge clk);
		check(time_ms, 0);
		summarize();
	end
endmodule : testbench
